// *** include/isr_pkg.sv ***
// Purpose: shared constants and types of the start and reservation control block
// Assumes: 8-bit register port, 10 MHz ref_clk
// Notes: wait figures are counted in ref_clk cycles before prescaling
package isr_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CLOCK_SEL = 8'h04;
   localparam logic [7:0] OFS_FLAG = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_SHIFT_DATA = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   // control register bits
   localparam int CB_ENABLE = 0;
   localparam int CB_START = 1;
   localparam int CB_STOP = 2;
   localparam int CB_EXIT = 3;
   localparam int CB_STOP_IRQ = 4;
   // flag register bits
   localparam int FB_RSV_DIS = 0;
   localparam int FB_INIT_START = 1;
   localparam int FB_REJECTED = 2;
   localparam int FB_BUSY = 3;
   // status register bits
   localparam int SB_MASTER = 0;
   localparam int SB_SLAVE = 1;
   localparam int SB_WAIT = 2;
   localparam int SB_RESERVED = 3;
   // interrupt bits: stop seen, start seen, start rejected, reserved start fired
   localparam int IB_STOP = 0;
   localparam int IB_START = 1;
   localparam int IB_REJECT = 2;
   localparam int IB_FIRED = 3;
   localparam int IRQ_W = 4;
   localparam logic [6:0] CLOCK_SEL_RESET = 7'h00;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
   // settling waits at the undivided clock
   localparam logic [7:0] WAIT_STD_00 = 8'd26;
   localparam logic [7:0] WAIT_STD_01 = 8'd47;
   localparam logic [7:0] WAIT_STD_10 = 8'd47;
   localparam logic [7:0] WAIT_STD_11 = 8'd37;
   localparam logic [7:0] WAIT_FAST_0X = 8'd16;
   localparam logic [7:0] WAIT_FAST_10 = 8'd16;
   localparam logic [7:0] WAIT_FAST_11 = 8'd13;
   localparam logic [7:0] WAIT_EXT = 8'd10;
   localparam logic [7:0] WAIT_REJECT_UNIT = 8'd5;
   localparam logic [2:0] PRESCALE_OFFSET = 3'd2;

   typedef struct packed {
      logic prescaler_enable;
      logic prescaler_bit_high;
      logic prescaler_bit_low;
      logic clock_extension_bit;
      logic speed_mode_bit;
      logic rate_bit_high;
      logic rate_bit_low;
   } isr_clock_sel_t;

   typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_RESERVED, ST_WAIT, ST_HALT} isr_mode_t;
   typedef enum logic [1:0] {DC_START, DC_RESERVE, DC_REJECT, DC_NONE} isr_decide_t;

   typedef struct packed {
      logic scl_s1, scl_s2, scl_d;
      logic sda_s1, sda_s2, sda_d;
      logic controller_enable, start_request, stop_irq_enable;
      isr_clock_sel_t clock_sel;
      logic reservation_disable, initial_start_enable;
      logic start_rejected_flag, bus_busy_flag;
      logic master_status, slave_active;
      isr_mode_t mode;
      isr_decide_t decide;
      logic [7:0] cnt;
      logic [IRQ_W-1:0] irq_stat, irq_mask;
      logic [DATA_W-1:0] rdata, tx_data;
      logic start_gen, stop_gen, addr_go, irq;
   } isr_state_t;
endpackage

// *** rtl/isr_ctrl.sv ***
// Purpose: start request, communication reservation and bus-busy control of an I2C master
// Assumes: bus lines arrive asynchronously; arbitration and address events come from
//    the shifter on ref_clk; line drivers act on start_gen/stop_gen/addr_go pulses
// Notes: registers on a plain strobe port, read data one cycle after the read strobe
`timescale 1ns/1ps
module isr_ctrl
   import isr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic bus_clock_pin,
   input wire logic bus_data_pin,
   input wire logic arb_lost,
   input wire logic slave_addressed,
   output logic start_gen,
   output logic stop_gen,
   output logic addr_go,
   output logic [DATA_W-1:0] tx_data,
   output logic bus_interrupt
);
   isr_state_t s_reg;
   isr_state_t s_next;

   function automatic logic [7:0] base_wait(input isr_clock_sel_t c);
      logic [1:0] rate;
      rate = {c.rate_bit_high, c.rate_bit_low};
      if (c.clock_extension_bit)
         base_wait = WAIT_EXT;
      else if (c.speed_mode_bit)
         base_wait = (rate == 2'b11) ? WAIT_FAST_11 :
                     (rate == 2'b10) ? WAIT_FAST_10 : WAIT_FAST_0X;
      else
         case (rate)
            2'b00: base_wait = WAIT_STD_00;
            2'b01: base_wait = WAIT_STD_01;
            2'b10: base_wait = WAIT_STD_10;
            default: base_wait = WAIT_STD_11;
         endcase
   endfunction

   function automatic logic [2:0] divisor(input isr_clock_sel_t c);
      if (c.prescaler_enable)
         divisor = {1'b0, c.prescaler_bit_high, c.prescaler_bit_low} + PRESCALE_OFFSET;
      else
         divisor = 3'd1;
   endfunction

   logic wr_ctrl, wr_data, start_seen, stop_seen, device_idle;
   logic [10:0] settle_prod, reject_prod;

   assign wr_ctrl = reg_wr && (reg_addr == OFS_CONTROL);
   assign wr_data = reg_wr && (reg_addr == OFS_SHIFT_DATA);
   // edges read only second-stage and delayed copies, never the first stage
   assign start_seen = s_reg.scl_s2 && s_reg.scl_d && s_reg.sda_d && !s_reg.sda_s2;
   assign stop_seen = s_reg.scl_s2 && s_reg.scl_d && !s_reg.sda_d && s_reg.sda_s2;
   assign device_idle = !s_reg.master_status && !s_reg.slave_active;
   assign settle_prod = base_wait(s_reg.clock_sel) * divisor(s_reg.clock_sel);
   assign reject_prod = WAIT_REJECT_UNIT * divisor(s_reg.clock_sel);

   always_comb
   begin
      logic [IRQ_W-1:0] ev;
      logic [DATA_W-1:0] rd_val;
      ev = '0;
      rd_val = '0;
      s_next = s_reg;
      s_next.start_gen = 1'b0;
      s_next.stop_gen = 1'b0;
      s_next.addr_go = 1'b0;
      s_next.scl_s1 = bus_clock_pin;
      s_next.scl_s2 = s_reg.scl_s1;
      s_next.scl_d = s_reg.scl_s2;
      s_next.sda_s1 = bus_data_pin;
      s_next.sda_s2 = s_reg.sda_s1;
      s_next.sda_d = s_reg.sda_s2;

      if (s_reg.controller_enable)
      begin
         // line events keep the busy flag in step with traffic
         if (start_seen)
         begin
            s_next.bus_busy_flag = 1'b1;
            ev[IB_START] = 1'b1;
         end
         if (stop_seen)
         begin
            s_next.bus_busy_flag = 1'b0;
            s_next.slave_active = 1'b0;
            s_next.master_status = 1'b0;
            ev[IB_STOP] = 1'b1;
         end
         if (slave_addressed)
            s_next.slave_active = 1'b1;
         if (arb_lost)
            s_next.master_status = 1'b0;
      end

      case (s_reg.mode)
         ST_IDLE:
            ;
         ST_SETTLE:
            if (s_reg.cnt > 8'd1)
               s_next.cnt = s_reg.cnt - 8'd1;
            else
            begin
               s_next.start_request = 1'b0;
               s_next.mode = ST_IDLE;
               case (s_reg.decide)
                  DC_START:
                  begin
                     s_next.start_gen = 1'b1;
                     s_next.master_status = 1'b1;
                     s_next.bus_busy_flag = 1'b1;
                     s_next.mode = ST_WAIT;
                  end
                  DC_RESERVE:
                  begin
                     s_next.start_request = 1'b1;
                     s_next.mode = ST_RESERVED;
                  end
                  DC_REJECT:
                  begin
                     s_next.start_rejected_flag = 1'b1;
                     ev[IB_REJECT] = 1'b1;
                  end
                  default:
                     ;
               endcase
            end
         ST_RESERVED:
            if (slave_addressed || arb_lost)
            begin
               s_next.mode = ST_IDLE;
               s_next.start_request = 1'b0;
               s_next.master_status = 1'b0;
            end
            else if (stop_seen)
            begin
               s_next.start_gen = 1'b1;
               s_next.start_request = 1'b0;
               s_next.master_status = 1'b1;
               s_next.bus_busy_flag = 1'b1;
               ev[IB_FIRED] = 1'b1;
               // without the stop interrupt nobody is told to write data
               s_next.mode = s_reg.stop_irq_enable ? ST_WAIT : ST_HALT;
            end
         ST_WAIT:
            if (wr_data)
            begin
               s_next.addr_go = 1'b1;
               s_next.mode = ST_IDLE;
            end
            else if (!s_reg.master_status)
               s_next.mode = ST_IDLE;
         ST_HALT:
            if (!s_reg.master_status)
               s_next.mode = ST_IDLE;
         default:
            s_next.mode = ST_IDLE;
      endcase

      if (reg_wr)
         case (reg_addr)
            OFS_CONTROL:
            begin
               if (reg_wdata[CB_ENABLE] && !s_reg.controller_enable)
                  s_next.bus_busy_flag = !s_reg.initial_start_enable;
               if (!reg_wdata[CB_ENABLE])
               begin
                  // a start decided in this very cycle must not leave a disabled controller
                  s_next.start_gen = 1'b0;
                  s_next.mode = ST_IDLE;
                  s_next.master_status = 1'b0;
                  s_next.slave_active = 1'b0;
                  s_next.start_request = 1'b0;
               end
               s_next.controller_enable = reg_wdata[CB_ENABLE];
               s_next.stop_irq_enable = reg_wdata[CB_STOP_IRQ];
               s_next.irq_mask[IB_STOP] = reg_wdata[CB_STOP_IRQ];
               if (reg_wdata[CB_EXIT])
                  s_next.slave_active = 1'b0;
               if (!reg_wdata[CB_START] && s_reg.mode == ST_RESERVED)
               begin
                  s_next.start_request = 1'b0;
                  s_next.mode = ST_IDLE;
               end
               // a set while still set is ignored
               if (reg_wdata[CB_START] && !s_reg.start_request && s_reg.controller_enable
                   && (s_reg.mode == ST_IDLE || s_reg.mode == ST_WAIT
                   || s_reg.mode == ST_HALT))
               begin
                  s_next.start_request = 1'b1;
                  s_next.start_rejected_flag = 1'b0;
                  s_next.mode = ST_SETTLE;
                  if (s_reg.reservation_disable)
                  begin
                     s_next.cnt = reject_prod[7:0];
                     s_next.decide = (s_reg.bus_busy_flag && device_idle) ? DC_REJECT
                                   : (s_reg.slave_active ? DC_NONE : DC_START);
                  end
                  else
                  begin
                     s_next.cnt = settle_prod[7:0];
                     s_next.decide = !s_reg.bus_busy_flag ? DC_START
                                   : (device_idle ? DC_RESERVE
                                   : (s_reg.master_status ? DC_START : DC_NONE));
                  end
               end
               if (reg_wdata[CB_STOP] && s_reg.controller_enable)
               begin
                  s_next.stop_gen = 1'b1;
                  s_next.master_status = 1'b0;
                  s_next.bus_busy_flag = 1'b0;
                  s_next.mode = ST_IDLE;
               end
            end
            OFS_CLOCK_SEL:
               // a running controller must not see its bit timing change
               if (!s_reg.controller_enable)
                  s_next.clock_sel = isr_clock_sel_t'(reg_wdata[6:0]);
            OFS_FLAG:
            begin
               s_next.reservation_disable = reg_wdata[FB_RSV_DIS];
               s_next.initial_start_enable = reg_wdata[FB_INIT_START];
            end
            OFS_SHIFT_DATA:
               s_next.tx_data = reg_wdata;
            OFS_IRQ_MASK:
            begin
               s_next.irq_mask = reg_wdata[IRQ_W-1:0];
               s_next.stop_irq_enable = reg_wdata[IB_STOP];
            end
            default:
               ;
         endcase

      // write one clears; a new event in the same cycle wins
      if (reg_wr && reg_addr == OFS_IRQ_STATUS)
         s_next.irq_stat = s_reg.irq_stat & ~reg_wdata[IRQ_W-1:0];
      s_next.irq_stat = s_next.irq_stat | ev;
      s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

      if (reg_rd)
      begin
         case (reg_addr)
            OFS_CONTROL:
            begin
               rd_val[CB_ENABLE] = s_reg.controller_enable;
               rd_val[CB_START] = s_reg.start_request;
               rd_val[CB_STOP_IRQ] = s_reg.stop_irq_enable;
            end
            OFS_CLOCK_SEL:
               rd_val[6:0] = s_reg.clock_sel;
            OFS_FLAG:
            begin
               rd_val[FB_RSV_DIS] = s_reg.reservation_disable;
               rd_val[FB_INIT_START] = s_reg.initial_start_enable;
               rd_val[FB_REJECTED] = s_reg.start_rejected_flag;
               rd_val[FB_BUSY] = s_reg.bus_busy_flag;
            end
            OFS_STATUS:
            begin
               rd_val[SB_MASTER] = s_reg.master_status;
               rd_val[SB_SLAVE] = s_reg.slave_active;
               rd_val[SB_WAIT] = (s_reg.mode == ST_WAIT) || (s_reg.mode == ST_HALT);
               rd_val[SB_RESERVED] = (s_reg.mode == ST_RESERVED);
            end
            OFS_SHIFT_DATA:
               rd_val = s_reg.tx_data;
            OFS_IRQ_STATUS:
               rd_val[IRQ_W-1:0] = s_reg.irq_stat;
            OFS_IRQ_MASK:
               rd_val[IRQ_W-1:0] = s_reg.irq_mask;
            default:
               rd_val = '0;
         endcase
      end
      s_next.rdata = rd_val;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.scl_s1 <= 1'b1;
         s_reg.scl_s2 <= 1'b1;
         s_reg.scl_d <= 1'b1;
         s_reg.sda_s1 <= 1'b1;
         s_reg.sda_s2 <= 1'b1;
         s_reg.sda_d <= 1'b1;
         s_reg.clock_sel <= CLOCK_SEL_RESET;
         s_reg.irq_mask <= IRQ_MASK_RESET;
         s_reg.mode <= ST_IDLE;
         s_reg.decide <= DC_NONE;
      end
      else
         s_reg <= s_next;
   end

   assign reg_rdata = s_reg.rdata;
   assign start_gen = s_reg.start_gen;
   assign stop_gen = s_reg.stop_gen;
   assign addr_go = s_reg.addr_go;
   assign tx_data = s_reg.tx_data;
   assign bus_interrupt = s_reg.irq;
endmodule

// *** bench/isr_ctrl_assertions.sv ***
// Purpose: port-level checks of the start and reservation control
// Assumes: one ref_clk domain, rst asynchronous and active high
// Notes: bound to every isr_ctrl instance at the foot of this file
`timescale 1ns/1ps
module isr_ctrl_assertions
   import isr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic start_gen,
   input wire logic stop_gen,
   input wire logic addr_go,
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic bus_interrupt
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic en_reg;
   wire ctl_wr = reg_wr && reg_addr == OFS_CONTROL;
   wire data_wr = reg_wr && reg_addr == OFS_SHIFT_DATA;
   wire mask_off = reg_wr && reg_addr == OFS_IRQ_MASK && reg_wdata == 8'h00;
   // enable bit as software last wrote it; the body is not visible here
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         en_reg <= 1'b0;
      else if (ctl_wr)
         en_reg <= reg_wdata[CB_ENABLE];
   sequence s_start_wr;
      ctl_wr && reg_wdata[CB_START];
   endsequence
   sequence s_no_start;
      !start_gen [*4];
   endsequence
   property p_settle_min;
      s_start_wr |=> s_no_start;
   endproperty
   a_settle_min: assert property (p_settle_min) else $error("start before settling");
   property p_start_pulse;
      start_gen |=> !start_gen;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
   property p_start_en;
      start_gen |-> en_reg;
   endproperty
   a_start_en: assert property (p_start_en) else $error("start while disabled");
   property p_addr_cause;
      addr_go |-> $past(data_wr) && tx_data == $past(reg_wdata);
   endproperty
   a_addr_cause: assert property (p_addr_cause) else $error("address start uncaused");
   property p_tx_hold;
      $changed(tx_data) |-> $past(data_wr);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("shift data changed alone");
   property p_stop_cause;
      stop_gen |-> $past(ctl_wr && reg_wdata[CB_STOP]) || $past(ctl_wr && reg_wdata[CB_STOP], 2);
   endproperty
   a_stop_cause: assert property (p_stop_cause) else $error("stop uncaused");
   property p_stop_pulse;
      stop_gen |=> !stop_gen;
   endproperty
   a_stop_pulse: assert property (p_stop_pulse) else $error("stop pulse too long");
   property p_mask_off;
      mask_off |-> ##2 !bus_interrupt;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("masked interrupt high");
endmodule
bind isr_ctrl isr_ctrl_assertions i_isr_ctrl_assertions (.ref_clk(ref_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .start_gen(start_gen), .stop_gen(stop_gen), .addr_go(addr_go), .tx_data(tx_data),
   .bus_interrupt(bus_interrupt));

// *** bench/isr_bus_model.sv ***
// Purpose: another master on the shared bus lines
// Assumes: lines pulled up, so idle and released read high
// Notes: edges are offset from ref_clk edges to keep the synchronizer race-free
`timescale 1ns/1ps
module isr_bus_model
   import isr_pkg::*;
#(
   parameter int IDLE_FRAME_NS = 2030
)
(
   output logic bus_clock_pin,
   output logic bus_data_pin
);
   initial
   begin
      bus_clock_pin = 1'b1;
      bus_data_pin = 1'b1;
   end
   // takes the bus only after a whole frame of idle lines
   task automatic bus_start();
      #IDLE_FRAME_NS;
      bus_data_pin = 1'b0;
      #530;
      bus_clock_pin = 1'b0;
   endtask
   task automatic bus_stop();
      bus_data_pin = 1'b0;
      #530;
      bus_clock_pin = 1'b1;
      #530;
      bus_data_pin = 1'b1;
   endtask
endmodule

// *** bench/tb_isr_ctrl.sv ***
// Purpose: self-checking bench of the start and reservation control
// Assumes: 10 MHz ref_clk, far side modelled by isr_bus_model
// Notes: expected waits come from the clock selection each scenario writes
`timescale 1ns/1ps
module tb_isr_ctrl
   import isr_pkg::*;
;
   logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic arb_lost = 1'b0, slave_addressed = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, tx_data, rd_val;
   logic start_gen, stop_gen, addr_go, bus_interrupt, scl, sda;
   wire [2:0] pulses = {stop_gen, addr_go, start_gen};
   int n_errors = 0, checks = 0, cycles = 0;
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end
   isr_bus_model i_isr_bus_model (.bus_clock_pin(scl), .bus_data_pin(sda));
   isr_ctrl i_isr_ctrl (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_clock_pin(scl),
      .bus_data_pin(sda), .arb_lost(arb_lost), .slave_addressed(slave_addressed),
      .start_gen(start_gen), .stop_gen(stop_gen), .addr_go(addr_go), .tx_data(tx_data),
      .bus_interrupt(bus_interrupt));
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      rd_val = reg_rdata;
   endtask
   // n reaches lim when the chosen pulse never came
   task automatic wait_pulse(int sel, int lim, output int n);
      n = 0;
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while (pulses[sel] !== 1'b1 && n < lim);
   endtask
   task automatic setup(logic [7:0] flags, logic [7:0] clk_sel);
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_FLAG, flags);
      wr(OFS_CLOCK_SEL, clk_sel);
      wr(OFS_CONTROL, 8'h01);
   endtask
   task automatic t_enable();
      int n;
      setup(8'h00, 8'h00);
      rd(OFS_FLAG);
      check("busy after enable", rd_val, 8'h08);
      wr(OFS_CONTROL, 8'h05);
      wait_pulse(2, 4, n);
      check("stop pulse", n < 4, 1'b1);
      rd(OFS_FLAG);
      check("busy after stop", rd_val, 8'h00);
      setup(8'h02, 8'h00);
      rd(OFS_FLAG);
      check("free after enable", rd_val, 8'h02);
      rd(8'h1C);
      check("unmapped read", rd_val, 8'h00);
   endtask
   task automatic t_settle();
      logic [7:0] sel [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h0C, 8'h51, 8'h71};
      int exp [9] = '{26, 47, 47, 37, 16, 13, 10, 141, 235};
      int n;
      for (int i = 0; i < 9; i++)
      begin
         setup(8'h02, sel[i]);
         wr(OFS_CONTROL, 8'h03);
         wait_pulse(0, 300, n);
         // a pulse launched N edges after the write edge is seen at negedge N+1
         check("settle cycles", 8'(n - 1), 8'(exp[i]));
         rd(OFS_STATUS);
         check("master after start", rd_val & 8'h01, 8'h01);
      end
   endtask
   task automatic t_reserve(logic [7:0] ctl);
      int n;
      setup(8'h02, 8'h0C);
      i_isr_bus_model.bus_start();
      wr(OFS_CONTROL, ctl);
      wait_pulse(0, 20, n);
      check("no start while busy", n[7:0], 8'd20);
      rd(OFS_STATUS);
      check("reservation pending", rd_val & 8'h0F, 8'h08);
      i_isr_bus_model.bus_stop();
      wait_pulse(0, 10, n);
      check("reserved start fired", n < 10, 1'b1);
      rd(OFS_STATUS);
      check("wait after fire", rd_val & 8'h0F, 8'h05);
      wr(OFS_SHIFT_DATA, 8'hA5);
      wait_pulse(1, 6, n);
      check("address start", n[7:0], ctl[CB_STOP_IRQ] ? 8'h01 : 8'h06);
      check("address byte", tx_data, 8'hA5);
      check("stop interrupt", bus_interrupt, ctl[CB_STOP_IRQ]);
   endtask
   task automatic t_irq();
      wr(OFS_IRQ_MASK, 8'h00);
      rd(OFS_IRQ_STATUS);
      check("events held", rd_val, 8'h0B);
      check("masked interrupt", bus_interrupt, 1'b0);
      wr(OFS_IRQ_STATUS, 8'h0F);
      rd(OFS_IRQ_STATUS);
      check("events cleared", rd_val, 8'h00);
   endtask
   task automatic t_reject();
      int n;
      setup(8'h03, 8'h40);
      i_isr_bus_model.bus_start();
      wr(OFS_CONTROL, 8'h03);
      rd(OFS_FLAG);
      check("reject not yet", rd_val & 8'h04, 8'h00);
      wait_pulse(0, 12, n);
      check("no start on reject", n[7:0], 8'd12);
      rd(OFS_FLAG);
      check("start rejected", rd_val & 8'h04, 8'h04);
      rd(OFS_IRQ_STATUS);
      check("reject event", rd_val & 8'h04, 8'h04);
      i_isr_bus_model.bus_stop();
   endtask
   task automatic t_discard();
      int n;
      for (int i = 0; i < 2; i++)
      begin
         setup(8'h02, 8'h0C);
         i_isr_bus_model.bus_start();
         wr(OFS_CONTROL, 8'h13);
         repeat (14) @(negedge ref_clk);
         @(posedge ref_clk);
         slave_addressed <= (i == 0);
         arb_lost <= (i == 1);
         @(posedge ref_clk);
         slave_addressed <= 1'b0;
         arb_lost <= 1'b0;
         i_isr_bus_model.bus_stop();
         wait_pulse(0, 20, n);
         check("reservation dropped", n[7:0], 8'd20);
         rd(OFS_STATUS);
         check("master stays clear", rd_val & 8'h01, 8'h00);
      end
   endtask
   // addressed as slave: no start, no reservation until exit frees the device
   task automatic t_exit();
      int n;
      setup(8'h02, 8'h0C);
      i_isr_bus_model.bus_start();
      @(posedge ref_clk);
      slave_addressed <= 1'b1;
      @(posedge ref_clk);
      slave_addressed <= 1'b0;
      wr(OFS_CONTROL, 8'h03);
      wait_pulse(0, 20, n);
      check("no start as slave", n[7:0], 8'd20);
      rd(OFS_STATUS);
      check("slave, no reservation", rd_val & 8'h0F, 8'h02);
      wr(OFS_CONTROL, 8'h09);
      rd(OFS_STATUS);
      check("exit frees slave", rd_val & 8'h0F, 8'h00);
      wr(OFS_CONTROL, 8'h03);
      wait_pulse(0, 20, n);
      rd(OFS_STATUS);
      check("reserve after exit", rd_val & 8'h0F, 8'h08);
      i_isr_bus_model.bus_stop();
      wait_pulse(0, 10, n);
      check("start after exit", n < 10, 1'b1);
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         finish_test();
      end
   end
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      t_enable();
      t_settle();
      t_reserve(8'h13);
      t_irq();
      t_reserve(8'h03);
      t_reject();
      t_discard();
      t_exit();
      finish_test();
   end
endmodule
